// ### rtl/pmt_pkg.sv
// Constants, field positions and carrier types of the power-management timers.
// Assumes one 200 MHz clock; every pin is synchronous to it.
package pmt_pkg;

	// ----------------------------------------------------------------
	// Clock and timebase
	// ----------------------------------------------------------------
	localparam int CLK_PERIOD_NS = 5;
	localparam logic [14:0] TB_CNT_MAX = 15'h7FFF; // 32,768 slow edges, 1 s
	localparam logic [14:0] TB_MS_MASK = 15'h001F; // 32 slow edges, about 1 ms
	localparam logic [1:0] ACPI_REF_DIV_LAST = 2'h3; // Reference divided by four

	// ----------------------------------------------------------------
	// Configuration space indices
	// ----------------------------------------------------------------
	localparam logic [7:0] IDX_PM_ENABLE_FOUR = 8'h83;
	localparam logic [7:0] IDX_SECOND_STATUS = 8'h87;
	localparam logic [7:0] IDX_T1_COUNT = 8'h88;
	localparam logic [7:0] IDX_T1_CONTROL = 8'h89;
	localparam logic [7:0] IDX_T2_COUNT = 8'h8A;
	localparam logic [7:0] IDX_T2_CONTROL = 8'h8B;
	localparam logic [7:0] IDX_VIDEO_COUNT = 8'h8E;
	localparam logic [7:0] IDX_PIN_DIR = 8'h90;
	localparam logic [7:0] IDX_PIN_CONTROL = 8'h92;

	// ----------------------------------------------------------------
	// Memory and fixed I/O offsets
	// ----------------------------------------------------------------
	localparam logic [7:0] MEM_TOP_STATUS = 8'h00;
	localparam logic [7:0] MEM_TIMER_STATUS = 8'h04;
	localparam logic [7:0] MEM_ACPI_COUNT = 8'h1C;
	localparam logic [15:0] IO_ACPI_COUNT = 16'h121C;

	// ----------------------------------------------------------------
	// Field positions
	// ----------------------------------------------------------------
	localparam int EN4_T1_ENABLE = 0;
	localparam int EN4_T2_ENABLE = 1;
	localparam int EN4_ACPI_INT = 5;
	localparam int CTL1_T1_MS = 7;
	localparam int CTL2_VIDEO_FAST = 6;
	localparam int CTL2_T2_WIDE = 5;
	localparam int CTL2_T1_WIDE = 4;
	localparam int CTL2_T2_MS = 3;
	localparam int CTL2_PIN_RELOAD = 2;
	localparam int PIN_BIT = 7;
	localparam int TOP_TIMER_BIT = 9;
	localparam int TOP_ACPI_BIT = 0;
	localparam logic [7:0] CTL2_WRITE_MASK = 8'hFC; // Bits 1:0 reserved

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0] REG_RESET = 8'h00;
	localparam logic [23:0] ACPI_RESET = 24'hFFFFFC;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [3:0] {
		PMT_IDLE = 4'b0001,
		PMT_PEND = 4'b0010,
		PMT_RUN = 4'b0100,
		PMT_DONE = 4'b1000
	} pmt_state_t;

	typedef struct packed {
		logic wr;
		logic rd;
		logic [7:0] idx;
		logic [7:0] wdata;
	} pmt_cfg_req_t;

	typedef struct packed {
		logic en;
		logic wide;
		logic [7:0] count;
	} pmt_gp_ctl_t;

endpackage

// ### rtl/pmt_gp_timer.sv
// One down-counting inactivity timer with deferred load.
// Assumes tick is a one-cycle pulse of the selected timebase: second, millisecond or every slow edge.
`timescale 1ns/1ps
module pmt_gp_timer import pmt_pkg::*; (
	input wire logic clk,
	input wire logic nrst,
	input wire pmt_gp_ctl_t ctl,
	input wire logic restart,
	input wire logic reload,
	input wire logic tick,
	output logic expire,
	output logic [15:0] cnt
);

	pmt_state_t state_q, state_d;
	logic [15:0] cnt_q, cnt_d;
	logic en_q;
	logic expire_q, expire_d;

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		cnt_d = cnt_q;
		expire_d = 1'b0;
		if (!ctl.en) begin
			state_d = PMT_IDLE;
		end else if (restart || !en_q) begin
			state_d = PMT_PEND; // Load waits for the tick
		end else begin
			case (state_q)
				PMT_IDLE: state_d = PMT_PEND;
				PMT_PEND: begin
					if (tick) begin
						cnt_d = ctl.wide ? {ctl.count, 8'h00} : {8'h00, ctl.count};
						state_d = PMT_RUN;
					end
				end
				PMT_RUN: begin
					if (reload) begin
						state_d = PMT_PEND;
					end else if (tick) begin
						cnt_d = (cnt_q == 16'h0000) ? 16'h0000 : cnt_q - 16'h0001;
						if (cnt_q <= 16'h0001) begin
							expire_d = 1'b1;
							state_d = PMT_DONE;
						end
					end
				end
				PMT_DONE: state_d = PMT_DONE; // Idle until re-enabled or count rewritten
				default: state_d = PMT_IDLE;
			endcase
		end
	end

	// Registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= PMT_IDLE;
			cnt_q <= 16'h0000;
			en_q <= 1'b0;
			expire_q <= 1'b0;
		end else begin
			state_q <= state_d;
			cnt_q <= cnt_d;
			en_q <= ctl.en;
			expire_q <= expire_d;
		end
	end

	assign expire = expire_q;
	assign cnt = cnt_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	a_wide_load: assert property (
		(state_q == PMT_PEND) && tick && ctl.en && en_q && !restart && ctl.wide
		|=> cnt_q == {$past(ctl.count), 8'h00})
		else $error("wide load not count shifted by eight");
	a_load_waits: assert property (
		(state_q == PMT_PEND) && !tick |=> state_q != PMT_RUN)
		else $error("timer loaded without timebase tick");
	a_done_holds: assert property (
		(state_q == PMT_DONE) && ctl.en && !restart |=> state_q == PMT_DONE)
		else $error("expired timer left idle state on its own");

endmodule // pmt_gp_timer

// ### rtl/pmt_timers.sv
// Power-management timers: two inactivity timers, video idle timer, ACPI timer.
// Assumes all pins synchronous to clk; config, memory and fixed I/O read ports.
//
// What this block does
// - Video timer uses 1 ms or 32 us
// - Timer two scale bit picks 8/16 bit
// - Timer one scale bit picks 8/16 bit
// - Wide load puts count in upper byte
// - Timer two ticks per second or millisecond
// - Edge-select bit picks rising or falling
// - ACPI counter advances at reference over four
// - Bit 23 change raises interrupt when enabled
// - ACPI count resets to 00FFFFFC
// - Fixed I/O read matches memory read
// - ACPI event sets second-level status bit
// - Expired timer interrupts, stays idle
// - Timer loads only on its selected timebase tick
`timescale 1ns/1ps
module pmt_timers import pmt_pkg::*; (
	input wire logic clk,
	input wire logic nrst,
	input wire pmt_cfg_req_t cfg_req,
	output logic [7:0] cfg_rdata,
	input wire logic mem_rd,
	input wire logic [7:0] mem_addr,
	output logic [31:0] mem_rdata,
	input wire logic io_rd,
	input wire logic [15:0] io_addr,
	output logic [31:0] io_rdata,
	input wire logic slow_timebase_clock,
	input wire logic acpi_ref_clock,
	input wire logic reload_trigger_pin,
	input wire logic [7:0] dev_activity,
	output logic mgmt_interrupt
);

	// Rising edge of a sampled level
	function automatic logic rise(input logic prev, input logic cur);
		rise = cur & ~prev;
	endfunction

	// ----------------------------------------------------------------
	// Configuration registers
	// ----------------------------------------------------------------
	logic [7:0] en4_q, en4_d, cnt1_q, cnt1_d, ctl1_q, ctl1_d, cnt2_q, cnt2_d;
	logic [7:0] ctl2_q, ctl2_d, vid_q, vid_d, dir_q, dir_d, pctl_q, pctl_d;
	logic [7:0] cfg_rdata_q, cfg_rdata_d;
	logic acpi_sts_q, acpi_sts_d;
	logic wr1, wr2, wrv;

	// Write decode and read mux
	always_comb begin
		en4_d = en4_q;
		cnt1_d = cnt1_q;
		ctl1_d = ctl1_q;
		cnt2_d = cnt2_q;
		ctl2_d = ctl2_q;
		vid_d = vid_q;
		dir_d = dir_q;
		pctl_d = pctl_q;
		if (cfg_req.wr) begin
			case (cfg_req.idx)
				IDX_PM_ENABLE_FOUR: en4_d = cfg_req.wdata;
				IDX_T1_COUNT: cnt1_d = cfg_req.wdata;
				IDX_T1_CONTROL: ctl1_d = cfg_req.wdata;
				IDX_T2_COUNT: cnt2_d = cfg_req.wdata;
				IDX_T2_CONTROL: ctl2_d = cfg_req.wdata & CTL2_WRITE_MASK;
				IDX_VIDEO_COUNT: vid_d = cfg_req.wdata;
				IDX_PIN_DIR: dir_d = cfg_req.wdata;
				IDX_PIN_CONTROL: pctl_d = cfg_req.wdata;
				default: en4_d = en4_q;
			endcase
		end
		case (cfg_req.idx)
			IDX_PM_ENABLE_FOUR: cfg_rdata_d = en4_q;
			IDX_SECOND_STATUS: cfg_rdata_d = {7'h00, acpi_sts_q};
			IDX_T1_COUNT: cfg_rdata_d = cnt1_q;
			IDX_T1_CONTROL: cfg_rdata_d = ctl1_q;
			IDX_T2_COUNT: cfg_rdata_d = cnt2_q;
			IDX_T2_CONTROL: cfg_rdata_d = ctl2_q;
			IDX_VIDEO_COUNT: cfg_rdata_d = vid_q;
			IDX_PIN_DIR: cfg_rdata_d = dir_q;
			IDX_PIN_CONTROL: cfg_rdata_d = pctl_q;
			default: cfg_rdata_d = 8'h00;
		endcase
		if (!cfg_req.rd) begin
			cfg_rdata_d = cfg_rdata_q;
		end
	end

	assign wr1 = cfg_req.wr && (cfg_req.idx == IDX_T1_COUNT);
	assign wr2 = cfg_req.wr && (cfg_req.idx == IDX_T2_COUNT);
	assign wrv = cfg_req.wr && (cfg_req.idx == IDX_VIDEO_COUNT);

	// Configuration registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			en4_q <= REG_RESET;
			cnt1_q <= REG_RESET;
			ctl1_q <= REG_RESET;
			cnt2_q <= REG_RESET;
			ctl2_q <= REG_RESET;
			vid_q <= REG_RESET;
			dir_q <= REG_RESET;
			pctl_q <= REG_RESET;
			cfg_rdata_q <= REG_RESET;
		end else begin
			en4_q <= en4_d;
			cnt1_q <= cnt1_d;
			ctl1_q <= ctl1_d;
			cnt2_q <= cnt2_d;
			ctl2_q <= ctl2_d;
			vid_q <= vid_d;
			dir_q <= dir_d;
			pctl_q <= pctl_d;
			cfg_rdata_q <= cfg_rdata_d;
		end
	end

	// ----------------------------------------------------------------
	// Timebase and pin sampling
	// ----------------------------------------------------------------
	logic slow_q, slow_prev_q, ref_q, ref_prev_q, pin_q, pin_prev_q;
	logic [14:0] tb_q, tb_d;
	logic slow_edge, tick_32us, tick_ms, tick_sec, tick_t1, tick_t2, tick_vid;

	assign slow_edge = rise(slow_prev_q, slow_q);
	assign tick_32us = slow_edge;
	assign tick_ms = slow_edge && ((tb_q & TB_MS_MASK) == TB_MS_MASK);
	assign tick_sec = slow_edge && (tb_q == TB_CNT_MAX);
	assign tick_vid = ctl2_q[CTL2_VIDEO_FAST] ? tick_32us : tick_ms;
	assign tick_t1 = ctl1_q[CTL1_T1_MS] ? tick_ms : tick_sec;
	assign tick_t2 = ctl2_q[CTL2_T2_MS] ? tick_ms : tick_sec;

	// Free-running timebase counter
	always_comb begin
		tb_d = slow_edge ? tb_q + 15'h0001 : tb_q;
	end

	// Samples and timebase
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			slow_q <= 1'b0;
			slow_prev_q <= 1'b0;
			ref_q <= 1'b0;
			ref_prev_q <= 1'b0;
			pin_q <= 1'b0;
			pin_prev_q <= 1'b0;
			tb_q <= 15'h0000;
		end else begin
			slow_q <= slow_timebase_clock;
			slow_prev_q <= slow_q;
			ref_q <= acpi_ref_clock;
			ref_prev_q <= ref_q;
			pin_q <= reload_trigger_pin;
			pin_prev_q <= pin_q;
			tb_q <= tb_d;
		end
	end

	// ----------------------------------------------------------------
	// Inactivity and video timers
	// ----------------------------------------------------------------
	logic pin_hit, reload_t2, reload_t1;
	logic exp1, exp2, expv;
	pmt_gp_ctl_t c1, c2, cv;

	// Edge select, then enable and direction gating
	assign pin_hit = pctl_q[PIN_BIT] ? rise(pin_q, pin_prev_q) : rise(pin_prev_q, pin_q);
	assign reload_t2 = pin_hit && ctl2_q[CTL2_PIN_RELOAD] && !dir_q[PIN_BIT];
	assign reload_t1 = |(dev_activity & {ctl2_q[7], ctl1_q[6:0]});
	assign c1 = '{en: en4_q[EN4_T1_ENABLE], wide: ctl2_q[CTL2_T1_WIDE], count: cnt1_q};
	assign c2 = '{en: en4_q[EN4_T2_ENABLE], wide: ctl2_q[CTL2_T2_WIDE], count: cnt2_q};
	assign cv = '{en: (vid_q != 8'h00), wide: 1'b0, count: vid_q};

	pmt_gp_timer u_t1 (
		.clk(clk),
		.nrst(nrst),
		.ctl(c1),
		.restart(wr1),
		.reload(reload_t1),
		.tick(tick_t1),
		.expire(exp1),
		.cnt()
	);

	pmt_gp_timer u_t2 (
		.clk(clk),
		.nrst(nrst),
		.ctl(c2),
		.restart(wr2),
		.reload(reload_t2),
		.tick(tick_t2),
		.expire(exp2),
		.cnt()
	);

	pmt_gp_timer u_vid (
		.clk(clk),
		.nrst(nrst),
		.ctl(cv),
		.restart(wrv),
		.reload(1'b0),
		.tick(tick_vid),
		.expire(expv),
		.cnt()
	);

	// ----------------------------------------------------------------
	// ACPI timer, status and read ports
	// ----------------------------------------------------------------
	logic [23:0] acpi_q, acpi_d;
	logic [1:0] div_q, div_d;
	logic acpi_tick, acpi_evt;
	logic [2:0] gp_sts_q, gp_sts_d;
	logic [31:0] mem_rdata_q, mem_rdata_d, io_rdata_q, io_rdata_d, acpi_word;
	logic irq_q, irq_d;

	assign acpi_tick = rise(ref_prev_q, ref_q) && (div_q == ACPI_REF_DIV_LAST);
	assign acpi_word = {8'h00, acpi_q};

	// Counter, sticky flags and read data
	always_comb begin
		div_d = rise(ref_prev_q, ref_q) ? div_q + 2'h1 : div_q;
		acpi_d = acpi_tick ? acpi_q + 24'h000001 : acpi_q;
		acpi_evt = en4_q[EN4_ACPI_INT] && (acpi_d[23] != acpi_q[23]);
		acpi_sts_d = acpi_sts_q;
		if (cfg_req.rd && (cfg_req.idx == IDX_SECOND_STATUS)) begin
			acpi_sts_d = 1'b0;
		end
		if (acpi_evt) begin
			acpi_sts_d = 1'b1;
		end
		gp_sts_d = gp_sts_q;
		if (mem_rd && (mem_addr == MEM_TIMER_STATUS)) begin
			gp_sts_d = 3'h0;
		end
		gp_sts_d = gp_sts_d | {expv, exp2, exp1};
		irq_d = acpi_sts_d || (gp_sts_d != 3'h0);
		mem_rdata_d = mem_rdata_q;
		if (mem_rd) begin
			case (mem_addr)
				MEM_TOP_STATUS: begin
					mem_rdata_d = 32'h00000000;
					mem_rdata_d[TOP_TIMER_BIT] = |gp_sts_q;
					mem_rdata_d[TOP_ACPI_BIT] = acpi_sts_q;
				end
				MEM_TIMER_STATUS: mem_rdata_d = {29'h00000000, gp_sts_q};
				MEM_ACPI_COUNT: mem_rdata_d = acpi_word;
				default: mem_rdata_d = 32'h00000000;
			endcase
		end
		io_rdata_d = io_rdata_q;
		if (io_rd) begin
			io_rdata_d = (io_addr == IO_ACPI_COUNT) ? acpi_word : 32'h00000000;
		end
	end

	// ACPI and status registers
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			acpi_q <= ACPI_RESET;
			div_q <= 2'h0;
			acpi_sts_q <= 1'b0;
			gp_sts_q <= 3'h0;
			mem_rdata_q <= 32'h00000000;
			io_rdata_q <= 32'h00000000;
			irq_q <= 1'b0;
		end else begin
			acpi_q <= acpi_d;
			div_q <= div_d;
			acpi_sts_q <= acpi_sts_d;
			gp_sts_q <= gp_sts_d;
			mem_rdata_q <= mem_rdata_d;
			io_rdata_q <= io_rdata_d;
			irq_q <= irq_d;
		end
	end

	assign cfg_rdata = cfg_rdata_q;
	assign mem_rdata = mem_rdata_q;
	assign io_rdata = io_rdata_q;
	assign mgmt_interrupt = irq_q;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);

	a_acpi_step: assert property (
		acpi_tick |=> acpi_q == $past(acpi_q) + 24'h000001)
		else $error("ACPI counter missed its step");
	a_acpi_still: assert property (
		!acpi_tick |=> $stable(acpi_q))
		else $error("ACPI counter moved without a tick");
	a_acpi_irq: assert property (
		acpi_evt |=> acpi_sts_q ##1 mgmt_interrupt)
		else $error("bit 23 change raised no interrupt");
	a_acpi_off: assert property (
		!en4_q[EN4_ACPI_INT] && !acpi_sts_q |=> !acpi_sts_q)
		else $error("ACPI status set while disabled");
	a_io_matches: assert property (
		io_rd && (io_addr == IO_ACPI_COUNT) |=> io_rdata == {8'h00, $past(acpi_q)})
		else $error("fixed port count differs from counter");
	a_count_top: assert property (
		mem_rd && (mem_addr == MEM_ACPI_COUNT) |=> mem_rdata[31:24] == 8'h00 && mem_rdata[23:0] == $past(acpi_q))
		else $error("ACPI count read has wrong content");
	a_pin_gated: assert property (
		!ctl2_q[CTL2_PIN_RELOAD] |-> !reload_t2)
		else $error("pin reload while disabled");
	a_ms_tick: assert property (
		tick_t2 |-> slow_edge && (ctl2_q[CTL2_T2_MS] ? tb_q[4:0] == 5'h1F : tb_q == TB_CNT_MAX))
		else $error("timer two tick off its timebase");

endmodule // pmt_timers

// ### verification/pmt_timers_test.sv
// Self-checking bench of the power-management timers.
// Assumes a 200 MHz clock and a fast slow timebase: one slow edge every 4 clocks.
`timescale 1ns/1ps
module pmt_timers_test import pmt_pkg::*;;
	logic clk;
	logic nrst;
	pmt_cfg_req_t cfg_req;
	logic [7:0] cfg_rdata;
	logic mem_rd;
	logic [7:0] mem_addr;
	logic [31:0] mem_rdata;
	logic io_rd;
	logic [15:0] io_addr;
	logic [31:0] io_rdata;
	logic slow_timebase_clock;
	logic acpi_ref_clock;
	logic reload_trigger_pin;
	logic [7:0] dev_activity;
	logic mgmt_interrupt;
	logic [1:0] slow_div;
	int failures = 0;
	int num_checks = 0;
	int cycles = 0;

	pmt_timers dut (
		.clk(clk),
		.nrst(nrst),
		.cfg_req(cfg_req),
		.cfg_rdata(cfg_rdata),
		.mem_rd(mem_rd),
		.mem_addr(mem_addr),
		.mem_rdata(mem_rdata),
		.io_rd(io_rd),
		.io_addr(io_addr),
		.io_rdata(io_rdata),
		.slow_timebase_clock(slow_timebase_clock),
		.acpi_ref_clock(acpi_ref_clock),
		.reload_trigger_pin(reload_trigger_pin),
		.dev_activity(dev_activity),
		.mgmt_interrupt(mgmt_interrupt)
	);

	// ------------------------------------------------------------
	// Clocks and watchdog
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// Slow timebase toggles every 2 clocks, so 1 ms tick is 128 clocks
	always @(posedge clk) begin
		#1;
		slow_div = slow_div + 2'h1;
		slow_timebase_clock = slow_div[1];
	end

	// Cuts a hang short
	always @(posedge clk) begin
		cycles = cycles + 1;
		if (cycles == 95000) begin
			failures++;
			results();
		end
	end

	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic results();
		$display("checks %0d failures %0d", num_checks, failures);
		if (failures == 0 && num_checks > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic do_reset();
		nrst = 1'b0;
		repeat (12) @(posedge clk);
		#1;
		nrst = 1'b1;
	endtask

	task automatic cfg_wr(input logic [7:0] idx, input logic [7:0] d);
		@(posedge clk);
		#1;
		cfg_req = '{wr: 1'b1, rd: 1'b0, idx: idx, wdata: d};
		@(posedge clk);
		#1;
		cfg_req = '0;
	endtask

	task automatic cfg_rd(input logic [7:0] idx, output logic [7:0] d);
		@(posedge clk);
		#1;
		cfg_req = '{wr: 1'b0, rd: 1'b1, idx: idx, wdata: 8'h00};
		@(posedge clk);
		#1;
		cfg_req = '0;
		@(posedge clk);
		#1;
		d = cfg_rdata;
	endtask

	// Word read through memory space or the fixed port
	task automatic rd32(input logic io, input logic [15:0] a, output logic [31:0] d);
		@(posedge clk);
		#1;
		mem_rd = ~io;
		io_rd = io;
		mem_addr = a[7:0];
		io_addr = a;
		@(posedge clk);
		#1;
		mem_rd = 1'b0;
		io_rd = 1'b0;
		@(posedge clk);
		#1;
		d = io ? io_rdata : mem_rdata;
	endtask

	// Reference clock: high 2 clocks, low 2 clocks per pulse
	task automatic ref_pulses(input int n);
		repeat (2 * n) begin
			repeat (2) @(posedge clk);
			#1;
			acpi_ref_clock = ~acpi_ref_clock;
		end
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic test_regs();
		logic [7:0] b;
		logic [31:0] w;
		do_reset();
		cfg_rd(IDX_PM_ENABLE_FOUR, b);
		check("enable four reset", b, 8'h00);
		cfg_wr(IDX_T2_CONTROL, 8'hFF);
		cfg_rd(IDX_T2_CONTROL, b);
		check("control two reserved", b, 8'hFC);
		rd32(1'b0, 16'h0008, w);
		check("unmapped offset", w, 32'h0);
		rd32(1'b1, 16'h1220, w);
		check("other port", w, 32'h0);
		$display("test regs done");
	endtask

	task automatic test_acpi(input logic en);
		logic [31:0] w;
		logic [7:0] b;
		do_reset();
		rd32(1'b0, 16'h001C, w);
		check("acpi mem reset", w, 32'h00FFFFFC);
		rd32(1'b1, IO_ACPI_COUNT, w);
		check("acpi io reset", w, 32'h00FFFFFC);
		cfg_wr(IDX_PM_ENABLE_FOUR, {2'h0, en, 5'h00});
		ref_pulses(4);
		rd32(1'b0, 16'h001C, w);
		check("acpi step", w, 32'h00FFFFFD);
		ref_pulses(12);
		repeat (4) @(posedge clk);
		#1;
		rd32(1'b1, IO_ACPI_COUNT, w);
		check("acpi wrap", w, 32'h00000000);
		check("acpi irq", mgmt_interrupt, en);
		rd32(1'b0, 16'h0000, w);
		check("top status", w[0], en);
		cfg_rd(IDX_SECOND_STATUS, b);
		check("second status", b[0], en);
		$display("test acpi enable %0b done", en);
	endtask

	// Program a timer, optionally flip the pin and pulse activity, time the interrupt
	// Lo above hi: no interrupt expected within hi cycles
	task automatic run_timer(input string name, input logic [7:0] idx, cnt, c89, c8b, e83, c90, c92,
		input logic pin0, input int edge_at, lo, hi);
		int n;
		reload_trigger_pin = pin0;
		do_reset();
		cfg_wr(IDX_T1_CONTROL, c89);
		cfg_wr(IDX_T2_CONTROL, c8b);
		cfg_wr(IDX_PIN_DIR, c90);
		cfg_wr(IDX_PIN_CONTROL, c92);
		cfg_wr(idx, cnt);
		cfg_wr(IDX_PM_ENABLE_FOUR, e83);
		n = 0;
		while (mgmt_interrupt !== 1'b1 && n <= hi) begin
			@(posedge clk);
			#1;
			n++;
			if (n == edge_at) begin
				reload_trigger_pin = ~pin0;
			end
			dev_activity = (n == edge_at) ? 8'hFF : 8'h00;
		end
		check(name, (n >= lo) && ((n <= hi) || (lo > hi)), 1'b1);
		$display("test %s done after %0d cycles", name, n);
	endtask

	// Status after expiry, clear on read, then the timer stays idle
	task automatic after_expiry(input logic [2:0] mask);
		logic [31:0] w;
		rd32(1'b0, 16'h0000, w);
		check("top timer status", w[9], 1'b1);
		rd32(1'b0, 16'h0004, w);
		check("timer status", w[2:0], mask);
		rd32(1'b0, 16'h0004, w);
		check("timer status cleared", w[2:0], 3'h0);
		repeat (768) @(posedge clk);
		#1;
		check("expired stays idle", mgmt_interrupt, 1'b0);
	endtask

	// ------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------
	initial begin
		nrst = 1'b0;
		cfg_req = '0;
		mem_rd = 1'b0;
		mem_addr = 8'h00;
		io_rd = 1'b0;
		io_addr = 16'h0000;
		acpi_ref_clock = 1'b0;
		reload_trigger_pin = 1'b0;
		dev_activity = 8'h00;
		slow_div = 2'h0;
		slow_timebase_clock = 1'b0;
		test_regs();
		test_acpi(1'b0);
		test_acpi(1'b1);
		run_timer("t2 narrow", IDX_T2_COUNT, 8'h03, 8'h00, 8'h08, 8'h02, 8'h00, 8'h00, 1'b0, 0, 380, 520);
		after_expiry(3'h2);
		run_timer("t2 second base", IDX_T2_COUNT, 8'h01, 8'h00, 8'h00, 8'h02, 8'h00, 8'h00, 1'b0, 0, 601, 600);
		run_timer("t1 narrow", IDX_T1_COUNT, 8'h02, 8'h80, 8'h00, 8'h01, 8'h00, 8'h00, 1'b0, 0, 252, 392);
		run_timer("t1 activity", IDX_T1_COUNT, 8'h02, 8'h81, 8'h00, 8'h01, 8'h00, 8'h00, 1'b0, 200, 450, 520);
		run_timer("video fast", IDX_VIDEO_COUNT, 8'h04, 8'h00, 8'h40, 8'h00, 8'h00, 8'h00, 1'b0, 0, 12, 32);
		after_expiry(3'h4);
		run_timer("video slow", IDX_VIDEO_COUNT, 8'h04, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 0, 508, 650);
		run_timer("pin rise", IDX_T2_COUNT, 8'h03, 8'h00, 8'h0C, 8'h02, 8'h00, 8'h00, 1'b0, 320, 700, 850);
		run_timer("pin rise ignored", IDX_T2_COUNT, 8'h03, 8'h00, 8'h0C, 8'h02, 8'h00, 8'h80, 1'b0, 320, 380, 520);
		run_timer("pin fall", IDX_T2_COUNT, 8'h03, 8'h00, 8'h0C, 8'h02, 8'h00, 8'h80, 1'b1, 320, 700, 850);
		run_timer("pin reload off", IDX_T2_COUNT, 8'h03, 8'h00, 8'h08, 8'h02, 8'h00, 8'h00, 1'b0, 320, 380, 520);
		run_timer("pin as output", IDX_T2_COUNT, 8'h03, 8'h00, 8'h0C, 8'h02, 8'h80, 8'h00, 1'b0, 320, 380, 520);
		run_timer("t1 wide", IDX_T1_COUNT, 8'h01, 8'h80, 8'h10, 8'h01, 8'h00, 8'h00, 1'b0, 0, 32764, 32904);
		run_timer("t2 wide", IDX_T2_COUNT, 8'h01, 8'h00, 8'h28, 8'h02, 8'h00, 8'h00, 1'b0, 0, 32764, 32904);
		results();
	end
endmodule // pmt_timers_test
